/* File: rtl/dac_config_register_bank.sv */
// dac_config_register_bank: configuration and status registers 0x00..linearization_voltage_limits of the DAC
// assumes a serial front end that hands over single-cycle byte reads and writes on mclk
`default_nettype none
module dac_config_register_bank #(
  parameter logic [1:0] build_variant = 2'h2 // value is arbitrary, names no real variant
) (
  input wire logic mclk,
  input wire logic nrst,
  // register port
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [6:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // status sources from analog or other clock domains
  input wire logic powerdown_pin_n,
  input wire logic sample_clock_present,
  input wire logic data_clock_present,
  input wire logic [7:0] phase_compare_bits,
  input wire logic [1:0] auto_sync_phase,
  // sample path
  input wire logic [15:0] sample_in,
  output logic [15:0] sample_out,
  // controls
  output logic core_powerdown,
  output logic whole_chip_powerdown,
  output logic sample_clock_rx_off,
  output logic divided_clock_out_off,
  output logic divided_clock_ratio,
  output logic divided_clock_drive_sel,
  output logic divided_clock_term_on,
  output logic data_clock_rx_on,
  output logic data_clock_quadrature,
  output logic [2:0] data_clock_delay,
  output logic port_a_rx_on,
  output logic port_b_rx_on,
  output logic single_port_select,
  output logic data_enable,
  output logic sync_manual_select,
  output logic [1:0] sync_phase_value,
  output logic linearizer_off,
  output logic [2:0] linearizer_gain,
  output logic [3:0] linearizer_vmax,
  output logic [3:0] linearizer_vmin
);
  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  // async status lines pass two flops; first stage read only by second
  logic [13:0] sync_meta;
  logic [13:0] sync_out;
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      sync_meta <= 14'h0000;
      sync_out <= 14'h0000;
    end else begin
      sync_meta <= {auto_sync_phase, phase_compare_bits, data_clock_present,
                    sample_clock_present, powerdown_pin_n, 1'b0};
      sync_out <= sync_meta;
    end
  end
  logic pin_up_s;
  logic sample_clock_present_s;
  logic dck_ok_s;
  logic [7:0] phase_s;
  logic [1:0] auto_phase_s;
  assign pin_up_s = sync_out[1];
  assign sample_clock_present_s = sync_out[2];
  assign dck_ok_s = sync_out[3];
  assign phase_s = sync_out[11:4];
  assign auto_phase_s = sync_out[13:12];

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  logic [7:0] ctrl_reg;
  logic [7:0] clk_reg;
  logic [7:0] dck_reg;
  logic [7:0] port_reg;
  logic [7:0] sync_reg;
  logic [7:0] lin_reg;
  logic [7:0] lim_reg;
  logic soft_reset;
  // soft reset synchronously reloads the reset values (zero, limits 0x08); the bit self-clears as part of it
  assign soft_reset = reg_write && (reg_addr == dac_cfg_pkg::reset_powerdown_control_addr)
                      && reg_wdata[dac_cfg_pkg::soft_reset_bit_pos];

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      ctrl_reg <= dac_cfg_pkg::zero_reset;
      clk_reg <= dac_cfg_pkg::zero_reset;
      dck_reg <= dac_cfg_pkg::zero_reset;
      port_reg <= dac_cfg_pkg::zero_reset;
      sync_reg <= dac_cfg_pkg::zero_reset;
      lin_reg <= dac_cfg_pkg::zero_reset;
      lim_reg <= dac_cfg_pkg::linearization_voltage_limits_reset;
    end else if (soft_reset) begin
      ctrl_reg <= dac_cfg_pkg::zero_reset;
      clk_reg <= dac_cfg_pkg::zero_reset;
      dck_reg <= dac_cfg_pkg::zero_reset;
      port_reg <= dac_cfg_pkg::zero_reset;
      sync_reg <= dac_cfg_pkg::zero_reset;
      lin_reg <= dac_cfg_pkg::zero_reset;
      lim_reg <= dac_cfg_pkg::linearization_voltage_limits_reset;
    end else if (reg_write) begin
      // masks drop read-only and reserved bits on write
      unique case (reg_addr)
        dac_cfg_pkg::reset_powerdown_control_addr: begin
          ctrl_reg <= reg_wdata & dac_cfg_pkg::reset_powerdown_control_mask;
        end
        dac_cfg_pkg::sample_clock_output_control_addr: begin
          clk_reg <= reg_wdata & dac_cfg_pkg::sample_clock_output_control_mask;
        end
        dac_cfg_pkg::data_clock_input_control_addr: begin
          dck_reg <= reg_wdata & dac_cfg_pkg::data_clock_input_control_mask;
        end
        dac_cfg_pkg::data_port_control_addr: begin
          port_reg <= reg_wdata & dac_cfg_pkg::data_port_control_mask;
        end
        dac_cfg_pkg::synchronizer_phase_control_addr: begin
          sync_reg <= reg_wdata & dac_cfg_pkg::synchronizer_phase_control_mask;
        end
        dac_cfg_pkg::linearization_control_addr: begin
          lin_reg <= reg_wdata & dac_cfg_pkg::linearization_control_mask;
        end
        dac_cfg_pkg::linearization_voltage_limits_addr: begin
          lim_reg <= reg_wdata & dac_cfg_pkg::linearization_voltage_limits_mask;
        end
        default: begin
          // reserved or read-only address: write ignored
          lim_reg <= lim_reg;
        end
      endcase
    end else if (!sync_reg[dac_cfg_pkg::sync_manual_select_pos]) begin
      // automatic mode tracks the synchroniser's own choice
      sync_reg[1:0] <= auto_phase_s;
    end
  end

  // ----------------------------------------------------------------
  // control outputs
  // ----------------------------------------------------------------
  assign core_powerdown = ctrl_reg[dac_cfg_pkg::core_powerdown_pos];
  assign whole_chip_powerdown = ctrl_reg[dac_cfg_pkg::whole_chip_powerdown_pos];
  assign sample_clock_rx_off = clk_reg[dac_cfg_pkg::sample_clock_rx_off_pos];
  assign divided_clock_out_off = clk_reg[dac_cfg_pkg::divided_clock_out_off_pos];
  assign divided_clock_ratio = clk_reg[dac_cfg_pkg::divided_clock_ratio_pos];
  assign divided_clock_drive_sel = clk_reg[dac_cfg_pkg::divided_clock_drive_sel_pos];
  assign divided_clock_term_on = clk_reg[dac_cfg_pkg::divided_clock_term_on_pos];
  assign data_clock_rx_on = dck_reg[dac_cfg_pkg::data_clock_rx_on_pos];
  assign data_clock_quadrature = dck_reg[dac_cfg_pkg::data_clock_quadrature_pos];
  assign data_clock_delay = dck_reg[dac_cfg_pkg::data_clock_delay_lsb +: 3];
  assign port_a_rx_on = port_reg[dac_cfg_pkg::port_a_rx_on_pos];
  assign port_b_rx_on = port_reg[dac_cfg_pkg::port_b_rx_on_pos];
  assign single_port_select = port_reg[dac_cfg_pkg::single_port_select_pos];
  assign data_enable = port_reg[dac_cfg_pkg::data_enable_pos];
  assign sync_manual_select = sync_reg[dac_cfg_pkg::sync_manual_select_pos];
  assign sync_phase_value = sync_reg[dac_cfg_pkg::sync_phase_value_lsb +: 2];
  assign linearizer_off = lin_reg[dac_cfg_pkg::linearizer_off_pos];
  assign linearizer_gain = lin_reg[dac_cfg_pkg::linearizer_gain_lsb +: 3];
  assign linearizer_vmax = lim_reg[dac_cfg_pkg::linearizer_vmax_lsb +: 4];
  assign linearizer_vmin = lim_reg[dac_cfg_pkg::linearizer_vmin_lsb +: 4];

  // ----------------------------------------------------------------
  // sample gate
  // ----------------------------------------------------------------
  // host must hold off data enable until the synchroniser settles
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      sample_out <= dac_cfg_pkg::mid_scale_code;
    end else if (data_enable) begin
      sample_out <= sample_in;
    end else begin
      sample_out <= dac_cfg_pkg::mid_scale_code;
    end
  end

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  logic [1:0] res_view;
  assign res_view = (pin_up_s && !whole_chip_powerdown) ? build_variant : 2'h0;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      reg_rdata <= 8'h00;
    end else if (reg_read) begin
      unique case (reg_addr)
        dac_cfg_pkg::reset_powerdown_control_addr: begin
          reg_rdata <= {2'h0, res_view, 1'b0, ctrl_reg[2:0]};
        end
        dac_cfg_pkg::sample_clock_output_control_addr: begin
          reg_rdata <= {clk_reg[7:4], 2'h0, sample_clock_present_s, clk_reg[0]};
        end
        dac_cfg_pkg::data_clock_input_control_addr: begin
          reg_rdata <= {1'b0, dck_reg[6:4], 1'b0, dck_reg[2], dck_ok_s, dck_reg[0]};
        end
        dac_cfg_pkg::data_port_control_addr: begin
          reg_rdata <= port_reg;
        end
        dac_cfg_pkg::synchronizer_phase_control_addr: begin
          reg_rdata <= sync_reg;
        end
        dac_cfg_pkg::phase_comparator_status_addr: begin
          reg_rdata <= phase_s;
        end
        dac_cfg_pkg::linearization_control_addr: begin
          reg_rdata <= lin_reg;
        end
        dac_cfg_pkg::linearization_voltage_limits_addr: begin
          reg_rdata <= lim_reg;
        end
        default: begin
          reg_rdata <= 8'h00;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

/* File: rtl/dac_cfg_pkg.sv */
// dac_cfg_pkg: offsets, field positions and reset values of the DAC register bank
// assumes byte-wide registers reached by a serial host through a parallel register port
`default_nettype none
package dac_cfg_pkg;
  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [6:0] reserved_zero_addr = 7'h00;
  localparam logic [6:0] reset_powerdown_control_addr = 7'h01;
  localparam logic [6:0] sample_clock_output_control_addr = 7'h02;
  localparam logic [6:0] data_clock_input_control_addr = 7'h03;
  localparam logic [6:0] data_port_control_addr = 7'h04;
  localparam logic [6:0] synchronizer_phase_control_addr = 7'h05;
  localparam logic [6:0] phase_comparator_status_addr = 7'h06;
  localparam logic [6:0] linearization_control_addr = 7'h07;
  localparam logic [6:0] linearization_voltage_limits_addr = 7'h08;
  // ----------------------------------------------------------------
  // writable-bit masks (reserved and read-only bits stay zero)
  // ----------------------------------------------------------------
  localparam logic [7:0] reset_powerdown_control_mask = 8'h07;
  localparam logic [7:0] sample_clock_output_control_mask = 8'hF1;
  localparam logic [7:0] data_clock_input_control_mask = 8'h75;
  localparam logic [7:0] data_port_control_mask = 8'h0F;
  localparam logic [7:0] synchronizer_phase_control_mask = 8'h07;
  localparam logic [7:0] linearization_control_mask = 8'h0F;
  localparam logic [7:0] linearization_voltage_limits_mask = 8'hFF;
  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] zero_reset = 8'h00;
  localparam logic [7:0] linearization_voltage_limits_reset = 8'h08;
  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int soft_reset_bit_pos = 0;
  localparam int core_powerdown_pos = 1;
  localparam int whole_chip_powerdown_pos = 2;
  localparam int resolution_indicator_lsb = 4;
  localparam int sample_clock_rx_off_pos = 0;
  localparam int sample_clock_present_pos = 1;
  localparam int divided_clock_out_off_pos = 4;
  localparam int divided_clock_ratio_pos = 5;
  localparam int divided_clock_drive_sel_pos = 6;
  localparam int divided_clock_term_on_pos = 7;
  localparam int data_clock_rx_on_pos = 0;
  localparam int data_clock_present_pos = 1;
  localparam int data_clock_quadrature_pos = 2;
  localparam int data_clock_delay_lsb = 4;
  localparam int port_a_rx_on_pos = 0;
  localparam int port_b_rx_on_pos = 1;
  localparam int single_port_select_pos = 2;
  localparam int data_enable_pos = 3;
  localparam int sync_phase_value_lsb = 0;
  localparam int sync_manual_select_pos = 2;
  localparam int linearizer_off_pos = 0;
  localparam int linearizer_gain_lsb = 1;
  localparam int linearizer_vmax_lsb = 0;
  localparam int linearizer_vmin_lsb = 4;
  // ----------------------------------------------------------------
  // data path
  // ----------------------------------------------------------------
  localparam logic [15:0] mid_scale_code = 16'h8000;
endpackage
`default_nettype wire

/* File: bench/dac_cfg_checker.sv */
// dac_cfg_checker: port checks for the config register bank
// assumes binding into dac_config_register_bank
`default_nettype none
module dac_cfg_checker (
  input wire logic mclk, nrst, reg_write, reg_read,
  input wire logic [6:0] reg_addr,
  input wire logic [7:0] reg_wdata, reg_rdata,
  input wire logic [15:0] sample_in, sample_out,
  input wire logic core_powerdown, whole_chip_powerdown, sample_clock_rx_off,
  input wire logic divided_clock_out_off, divided_clock_ratio, divided_clock_drive_sel,
  input wire logic divided_clock_term_on, data_clock_rx_on, data_clock_quadrature,
  input wire logic [2:0] data_clock_delay, linearizer_gain,
  input wire logic port_a_rx_on, port_b_rx_on, single_port_select, data_enable,
  input wire logic sync_manual_select, linearizer_off,
  input wire logic [1:0] sync_phase_value,
  input wire logic [3:0] linearizer_vmax, linearizer_vmin
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  // ----
  // write, read and sample path checks
  // ----
  sequence wr_at(logic [6:0] a);
    reg_write && reg_addr == a;
  endsequence
  chk_soft_reset_all: assert property (
    wr_at(7'h01) ##0 reg_wdata[0] |=> !core_powerdown && !data_enable && !port_a_rx_on
    && linearizer_vmax == 4'h8 && !sync_manual_select) else $error("soft reset missed");
  chk_powerdown_wr: assert property (
    wr_at(7'h01) ##0 !reg_wdata[0] |=> {whole_chip_powerdown, core_powerdown}
    == $past(reg_wdata[2:1])) else $error("powerdown bits wrong");
  chk_clock_wr: assert property (
    wr_at(7'h02) |=> {divided_clock_term_on, divided_clock_drive_sel, divided_clock_ratio,
    divided_clock_out_off, sample_clock_rx_off} == $past({reg_wdata[7:4], reg_wdata[0]}))
    else $error("clock bits wrong");
  chk_dclk_wr: assert property (
    wr_at(7'h03) |=> {data_clock_delay, data_clock_quadrature, data_clock_rx_on}
    == $past({reg_wdata[6:4], reg_wdata[2], reg_wdata[0]})) else $error("dclk bits wrong");
  chk_port_wr: assert property (
    wr_at(7'h04) |=> {data_enable, single_port_select, port_b_rx_on, port_a_rx_on}
    == $past(reg_wdata[3:0])) else $error("port bits wrong");
  chk_lin_gain_wr: assert property (
    wr_at(7'h07) |=> {linearizer_gain, linearizer_off} == $past(reg_wdata[3:0]))
    else $error("linearizer bits wrong");
  chk_lin_limit_wr: assert property (
    wr_at(7'h08) |=> {linearizer_vmin, linearizer_vmax} == $past(reg_wdata))
    else $error("limit bits wrong");
  chk_mid_scale: assert property (
    !data_enable |=> sample_out == 16'h8000) else $error("output not mid-scale");
  chk_sample_pass: assert property (
    data_enable |=> sample_out == $past(sample_in)) else $error("sample not passed");
  chk_manual_hold: assert property (
    sync_manual_select && !reg_write |=> $stable(sync_phase_value))
    else $error("manual phase moved");
  chk_unmapped_rd: assert property (
    reg_read && (reg_addr == 7'h00 || reg_addr > 7'h08) |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
endmodule
bind dac_config_register_bank dac_cfg_checker i_chk (.*);
`default_nettype wire

/* File: bench/dac_cfg_host.sv */
// dac_cfg_host: behavioural host on the parallel byte port
// assumes calls only after reset release, inputs change at falling edges
`default_nettype none
module dac_cfg_host (
  input wire logic mclk,
  input wire logic [7:0] reg_rdata,
  output logic reg_write = 1'b0,
  output logic reg_read = 1'b0,
  output logic [6:0] reg_addr = 7'h00,
  output logic [7:0] reg_wdata = 8'h00
);
  // data inverted when idle so a stale byte is never mistaken for a write
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(negedge mclk);
    reg_write = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge mclk);
    reg_write = 1'b0;
    reg_wdata = ~d;
  endtask
  task automatic rd(input logic [6:0] a, output logic [7:0] d);
    @(negedge mclk);
    reg_read = 1'b1;
    reg_addr = a;
    @(negedge mclk);
    reg_read = 1'b0;
    d = reg_rdata;
  endtask
endmodule
`default_nettype wire

/* File: bench/dac_config_register_bank_tb_top.sv */
// dac_config_register_bank_tb_top: directed register and sample path tests
// assumes the host model and the bound checker are compiled alongside
`default_nettype none
module dac_config_register_bank_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'b0, nrst = 1'b0, powerdown_pin_n = 1'b1;
  logic sample_clock_present = 1'b0, data_clock_present = 1'b0, reg_write, reg_read;
  logic [7:0] phase_compare_bits = 8'h00, reg_wdata, reg_rdata;
  logic [1:0] auto_sync_phase = 2'h0, sync_phase_value;
  logic [15:0] sample_in = 16'h0000, sample_out;
  logic [6:0] reg_addr;
  logic core_powerdown, whole_chip_powerdown, sample_clock_rx_off, divided_clock_out_off;
  logic divided_clock_ratio, divided_clock_drive_sel, divided_clock_term_on;
  logic data_clock_rx_on, data_clock_quadrature, port_a_rx_on, port_b_rx_on;
  logic single_port_select, data_enable, sync_manual_select, linearizer_off;
  logic [2:0] data_clock_delay, linearizer_gain;
  logic [3:0] linearizer_vmax, linearizer_vmin;
  int err_count = 0;
  int tests_run = 0;
  // variant value is arbitrary
  dac_config_register_bank #(.build_variant(2'h2)) i_dut (.*);
  dac_cfg_host i_host (.*);
  always #4 mclk = ~mclk;
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic rdchk(input logic [6:0] a, input logic [7:0] exp);
    logic [7:0] d;
    i_host.rd(a, d);
    check($sformatf("reg %h", a), {8'h00, exp}, {8'h00, d});
  endtask
  // ----
  // scenarios
  // ----
  task automatic test_reset_values;
    logic [7:0] e [9] = '{8'h00, 8'h20, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h08};
    for (int i = 0; i < 9; i++) rdchk(7'(i), e[i]);
    $display("done reset_values");
  endtask
  task automatic test_write_back;
    logic [6:0] a [11] = '{7'h01, 7'h02, 7'h03, 7'h04, 7'h05, 7'h07, 7'h08, 7'h00, 7'h06,
      7'h09, 7'h7F};
    logic [7:0] e [11] = '{8'h06, 8'hF1, 8'h75, 8'h0F, 8'h07, 8'h0F, 8'hFF, 8'h00, 8'h00,
      8'h00, 8'h00};
    for (int i = 0; i < 11; i++) begin
      i_host.wr(a[i], (a[i] == 7'h01) ? 8'hFE : 8'hFF);
      rdchk(a[i], e[i]);
    end
    $display("done write_back");
  endtask
  task automatic test_soft_reset;
    i_host.wr(7'h01, 8'h01);
    rdchk(7'h01, 8'h20);
    rdchk(7'h02, 8'h00);
    rdchk(7'h05, 8'h00);
    rdchk(7'h08, 8'h08);
    $display("done soft_reset");
  endtask
  task automatic test_status;
    powerdown_pin_n = 1'b0;
    sample_clock_present = 1'b1;
    data_clock_present = 1'b1;
    phase_compare_bits = 8'hA5;
    repeat (4) @(negedge mclk);
    rdchk(7'h01, 8'h00);
    rdchk(7'h02, 8'h02);
    rdchk(7'h03, 8'h02);
    rdchk(7'h06, 8'hA5);
    powerdown_pin_n = 1'b1;
    i_host.wr(7'h01, 8'h04);
    rdchk(7'h01, 8'h04);
    i_host.wr(7'h01, 8'h00);
    $display("done status");
  endtask
  task automatic test_sync_phase;
    auto_sync_phase = 2'h2;
    i_host.wr(7'h05, 8'h00);
    repeat (4) @(negedge mclk);
    rdchk(7'h05, 8'h02);
    check("sync_phase_value", 16'h0002, {14'h0000, sync_phase_value});
    i_host.wr(7'h05, 8'h05);
    auto_sync_phase = 2'h3;
    repeat (4) @(negedge mclk);
    rdchk(7'h05, 8'h05);
    $display("done sync_phase");
  endtask
  task automatic test_mid_scale;
    sample_in = 16'h1234;
    @(negedge mclk);
    check("sample_out", 16'h8000, sample_out);
    i_host.wr(7'h04, 8'h03);
    // receiver settle wait kept short; the real host waits far longer
    repeat (10) @(negedge mclk);
    i_host.wr(7'h04, 8'h0B);
    @(negedge mclk);
    check("sample_out", 16'h1234, sample_out);
    check("port bits", 16'h000B, {12'h000, data_enable, single_port_select, port_b_rx_on,
      port_a_rx_on});
    i_host.wr(7'h04, 8'h04);
    @(negedge mclk);
    check("sample_out", 16'h8000, sample_out);
    $display("done mid_scale");
  endtask
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (5) @(negedge mclk);
    nrst = 1'b1;
    test_reset_values;
    test_write_back;
    test_soft_reset;
    test_status;
    test_sync_phase;
    test_mid_scale;
    summarize;
  end
  // about 130 cycles expected; this allows about nineteen times that
  initial begin
    #20000;
    err_count++;
    summarize;
  end
endmodule
`default_nettype wire
